// >>> shared/tca_defs.vh
// Offsets, field positions, delivery values and timing counts of the config block.
`ifndef TCA_DEFS_VH
`define TCA_DEFS_VH
// ====================================================
// Register byte addresses on the bus.
`define TCA_CTRL_OFS      9'h000
`define TCA_STATUS_OFS    9'h004
`define TCA_ACCESS_OFS    9'h008
`define TCA_PAGE_BIT      8
// ====================================================
// Memory layout.
`define TCA_CFG_PAGE      6'h01
`define TCA_PAGE_COUNT    64
// ====================================================
// Field positions of the mode and lock byte.
`define TCA_AUTH_BIT      7
`define TCA_CODING_BIT    6
`define TCA_RATE_HI       5
`define TCA_RATE_LO       4
`define TCA_PCNT_HI       3
`define TCA_PCNT_LO       2
`define TCA_CFGLOCK_BIT   1
`define TCA_KEYLOCK_BIT   0
// ====================================================
// Control register bits.
`define TCA_CMD_SELECT    0
`define TCA_CMD_AUTH_OK   1
`define TCA_CMD_DESELECT  2
// ====================================================
// Delivery values loaded by the erase input, and the fixed size code.
`define TCA_MODE_INIT     8'h00
`define TCA_LOCK_INIT     8'h00
`define TCA_PWHI_INIT     8'hAA
`define TCA_SIZE_CODE     2'h2
// ====================================================
// Uplink bit lengths in carrier periods.
`define TCA_BITLEN_2K     7'h40
`define TCA_BITLEN_4K     7'h20
`define TCA_BITLEN_8K     7'h10
`endif

// >>> rtl/tca_top.v
// Configuration page store and access-rights checker of the transponder.
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "tca_defs.vh"

// How it works
// [RULE_01] Config in page 1, active after reset
// [RULE_02] Size code 00/01/10 is 32/256/2048 bit
// [RULE_03] Memory type byte reserved, never written
// [RULE_04] Plain mode: select command selects directly
// [RULE_05] Secure mode: select then good auth_sequence_a
// [RULE_06] Coding bit picks Manchester or biphase
// [RULE_07] Rate bits pick 4, 8, 2 kbit/s
// [RULE_08] Page count bits pick tag-first pages
// [RULE_09] Config lock freezes mode, page lock OTP
// [RULE_10] Config lock bit can never clear
// [RULE_11] Secure plus secret lock hides keys
// [RULE_12] Plain plus secret lock: pages 2-3 read-only
// [RULE_13] Reader sets config lock after secret lock
// [RULE_14] Page lock bits make groups read-only
// [RULE_15] Pigeon race keeps page 5 top writable
// [RULE_16] Refused writes leave contents unchanged
module tca_top
(
    input  wire        clk_in,              // System clock.
    input  wire        resetn_in,           // Asynchronous reset, low active.
    input  wire [8:0]  av_address_in,       // Avalon byte address.
    input  wire        av_read_in,          // Avalon read request.
    input  wire        av_write_in,         // Avalon write request.
    input  wire [31:0] av_writedata_in,     // Avalon write data.
    input  wire [3:0]  av_byteenable_in,    // Avalon byte enables.
    output reg  [31:0] av_readdata_out,     // Avalon read data.
    output wire        av_waitrequest_out,  // Avalon wait request.
    input  wire        nvm_init_in,         // Loads the delivery image.
    output reg         selected_out,        // Device is selected.
    output wire        tag_first_en_out,    // Tag-first transmission on.
    output wire        uplink_biphase_out,  // Biphase, else Manchester.
    output wire [6:0]  uplink_bit_len_out,  // Bit length in carrier periods.
    output wire [5:0]  tag_first_last_out,  // Last page sent in tag-first.
    output wire        pigeon_race_out      // Pigeon race standard on.
);

    // ====================================================
    // Storage.
    reg  [31:0] page_mem [0:`TCA_PAGE_COUNT-1]; // Nonvolatile pages.
    reg  [7:0]  nv_mode;          // Stored mode and lock byte.
    reg  [7:0]  nv_lock;          // Stored page lock byte.
    reg  [7:0]  nv_pw_hi;         // Stored high password byte.
    reg  [7:0]  eff_mode;         // Mode and lock byte in force.
    reg  [7:0]  eff_lock;         // Page lock byte in force.
    reg         load_pend;        // Copy pending after reset.
    reg         auth_pend;        // Waiting for a good auth_sequence_a.
    reg         ack;              // Bus answer phase.
    reg         wr_denied;        // Last write was refused.
    reg         rd_denied;        // Last read was refused.
    reg  [31:0] next_word;        // Page word after a write.
    reg         next_wr_denied;   // Some byte of a write refused.
    reg  [31:0] rd_word;          // Page word as seen by a read.
    reg         rd_bad;           // Read refused.
    reg  [7:0]  wb;               // Write byte under test.
    reg  [7:0]  ob;               // Old byte under test.
    integer     i;                // Byte loop index.
    integer     k;                // Page loop index of the store.

    wire [7:0]  mem_type = {6'h00, `TCA_SIZE_CODE}; // [RULE_02] [RULE_03]
    wire        req = av_read_in | av_write_in;
    wire        in_mem = av_address_in[`TCA_PAGE_BIT];
    wire [5:0]  pg = av_address_in[7:2];
    wire        auth = eff_mode[`TCA_AUTH_BIT];
    wire        cfg_lock = eff_mode[`TCA_CFGLOCK_BIT];
    wire        key_lock = eff_mode[`TCA_KEYLOCK_BIT];
    wire [1:0]  rate = eff_mode[`TCA_RATE_HI:`TCA_RATE_LO];
    wire [1:0]  pcnt = eff_mode[`TCA_PCNT_HI:`TCA_PCNT_LO];
    wire [31:0] cur_word = (pg == `TCA_CFG_PAGE) ?
                           {nv_pw_hi, nv_lock, nv_mode, mem_type} : page_mem[pg];

    // ====================================================
    // Functions.

    // Number of pages that the size code provides.
    function [6:0] size_pages;
        input [1:0] code;
        begin
            case (code)
                2'b01:   size_pages = 7'd8;
                2'b10:   size_pages = 7'd64;
                default: size_pages = 7'd1;
            endcase
        end
    endfunction

    // Lock bit that guards a data page from page 4 upward.
    function group_lock;
        input [5:0] page;
        input [7:0] locks;
        begin
            if (page < 6'd6)
                group_lock = locks[7];
            else if (page < 6'd8)
                group_lock = locks[6];
            else if (page < 6'd12)
                group_lock = locks[5];
            else if (page < 6'd16)
                group_lock = locks[4];
            else if (page < 6'd24)
                group_lock = locks[3];
            else if (page < 6'd32)
                group_lock = locks[2];
            else if (page < 6'd48)
                group_lock = locks[1];
            else
                group_lock = locks[0];
        end
    endfunction

    // Uplink bit length for the rate code.
    function [6:0] bit_len;
        input [1:0] code;
        begin
            case (code)
                2'b00:   bit_len = `TCA_BITLEN_4K;
                2'b01:   bit_len = `TCA_BITLEN_8K;
                default: bit_len = `TCA_BITLEN_2K;
            endcase
        end
    endfunction

    // ====================================================
    // Tag-first outputs decoded from the byte in force.
    assign uplink_biphase_out = eff_mode[`TCA_CODING_BIT];    // [RULE_06]
    assign uplink_bit_len_out = bit_len(rate);                // [RULE_07]
    assign pigeon_race_out    = (rate == 2'b11);              // [RULE_07]
    assign tag_first_en_out   = (pcnt != 2'b00);              // [RULE_08]
    assign tag_first_last_out = (pcnt == 2'b01) ? 6'd5 :
                                (pcnt == 2'b10) ? 6'd7 : 6'd4; // [RULE_08]

    // ====================================================
    // The bus waits one cycle, then answers.
    assign av_waitrequest_out = req & ~ack;

    // Next page word and refusal for a write to the addressed page.
    always @*
    begin
        next_word = cur_word;
        next_wr_denied = 1'b0;
        wb = 8'h00;
        ob = 8'h00;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (av_byteenable_in[i])
            begin
                wb = av_writedata_in[8*i +: 8];
                ob = cur_word[8*i +: 8];
                if ({1'b0, pg} >= size_pages(`TCA_SIZE_CODE) || pg == 6'd0)
                begin
                    // Absent pages and the identifier are never written.
                    next_wr_denied = 1'b1;                      // [RULE_16]
                end
                else if (pg == `TCA_CFG_PAGE)
                begin
                    if (i == 0)
                    begin
                        // The memory type byte is fixed.
                        next_wr_denied = 1'b1;                  // [RULE_03]
                    end
                    else if (i == 1)
                    begin
                        if (cfg_lock)
                            next_wr_denied = 1'b1;              // [RULE_09]
                        else
                            next_word[15:8] = {wb[7:2], wb[1] | ob[1], wb[0]}; // [RULE_10]
                    end
                    else if (i == 2)
                    begin
                        // Once frozen, lock bits can only be set.
                        next_word[23:16] = cfg_lock ? (ob | wb) : wb; // [RULE_09] [RULE_14]
                    end
                    else if (auth && key_lock)
                        next_wr_denied = 1'b1;                  // [RULE_11]
                    else
                        next_word[31:24] = wb;
                end
                else if (pg < 6'd4)
                begin
                    // Key pages are closed or read-only under the secret lock.
                    if (key_lock)
                        next_wr_denied = 1'b1;                  // [RULE_11] [RULE_12]
                    else
                        next_word[8*i +: 8] = wb;
                end
                else if (group_lock(pg, eff_lock[7:0]) &&
                         !(pg == 6'd5 && i >= 2 && rate == 2'b11))
                    next_wr_denied = 1'b1;                      // [RULE_14] [RULE_15]
                else
                    next_word[8*i +: 8] = wb;
            end
        end
    end

    // Page word as returned to a read, with hidden parts zeroed.
    always @*
    begin
        rd_word = cur_word;
        rd_bad = 1'b0;
        if ({1'b0, pg} >= size_pages(`TCA_SIZE_CODE))
        begin
            rd_word = 32'h0000_0000;
            rd_bad = 1'b1;
        end
        else if (auth && key_lock && (pg == 6'd2 || pg == 6'd3))
        begin
            rd_word = 32'h0000_0000;                            // [RULE_11]
            rd_bad = 1'b1;
        end
        else if (auth && key_lock && pg == `TCA_CFG_PAGE)
            rd_word[31:24] = 8'h00;                             // [RULE_11]
    end

    // ====================================================
    // Bus handshake, read data and access flags.
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ack <= 1'b0;
            av_readdata_out <= 32'h0000_0000;
            wr_denied <= 1'b0;
            rd_denied <= 1'b0;
        end
        else
        begin
            ack <= req & ~ack;
            if (av_read_in && !ack)
            begin
                // Data is captured so it stands when waitrequest drops.
                if (in_mem)
                begin
                    av_readdata_out <= rd_word;
                    rd_denied <= rd_bad;
                end
                else if (av_address_in == `TCA_STATUS_OFS)
                    av_readdata_out <= {8'h00, eff_lock, eff_mode,
                                        5'h00, auth_pend, load_pend, selected_out};
                else if (av_address_in == `TCA_ACCESS_OFS)
                    av_readdata_out <= {30'h0000_0000, rd_denied, wr_denied};
                else
                    av_readdata_out <= 32'h0000_0000;
            end
            if (av_write_in && ack && in_mem)
                wr_denied <= next_wr_denied;                    // [RULE_16]
        end
    end

    // ====================================================
    // Nonvolatile store; it keeps its contents across reset.
    always @(posedge clk_in)
    begin
        if (nvm_init_in)
        begin
            nv_mode <= `TCA_MODE_INIT;
            nv_lock <= `TCA_LOCK_INIT;
            nv_pw_hi <= `TCA_PWHI_INIT;
            // A loop index of its own keeps this process apart from the byte decode.
            for (k = 0; k < `TCA_PAGE_COUNT; k = k + 1)
                page_mem[k] <= 32'h0000_0000;
        end
        else if (av_write_in && ack && in_mem)
        begin
            // Refused bytes were left at their old value above.
            if (pg == `TCA_CFG_PAGE)
            begin
                nv_mode <= next_word[15:8];                     // [RULE_01]
                nv_lock <= next_word[23:16];
                nv_pw_hi <= next_word[31:24];
            end
            else
                page_mem[pg] <= next_word;                      // [RULE_16]
        end
    end

    // ====================================================
    // Copy of the config taken once after each reset release.
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            load_pend <= 1'b1;
            eff_mode <= 8'h00;
            eff_lock <= 8'h00;
        end
        else if (load_pend)
        begin
            load_pend <= 1'b0;
            eff_mode <= nv_mode;                                // [RULE_01]
            eff_lock <= nv_lock;                                // [RULE_01]
        end
    end

    // ====================================================
    // Selection from the reader's commands.
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            selected_out <= 1'b0;
            auth_pend <= 1'b0;
        end
        else if (av_write_in && ack && av_address_in == `TCA_CTRL_OFS && av_byteenable_in[0])
        begin
            if (av_writedata_in[`TCA_CMD_DESELECT])
            begin
                selected_out <= 1'b0;
                auth_pend <= 1'b0;
            end
            else if (av_writedata_in[`TCA_CMD_SELECT])
            begin
                // Plain mode selects at once, secure mode waits.
                selected_out <= ~auth;                          // [RULE_04]
                auth_pend <= auth;                              // [RULE_05]
            end
            else if (av_writedata_in[`TCA_CMD_AUTH_OK] && auth_pend)
            begin
                selected_out <= 1'b1;                           // [RULE_05]
                auth_pend <= 1'b0;
            end
        end
    end

endmodule

// >>> test/tca_chk.sv
// Port checker of the config page store and access checker.
`timescale 1ns/1ps
`include "tca_defs.vh"
module tca_chk
(
    input wire        clk_in,             // Clock.
    input wire        resetn_in,          // Reset, low active.
    input wire        av_read_in,         // Read request.
    input wire        av_write_in,        // Write request.
    input wire [31:0] av_readdata_out,    // Read data.
    input wire        av_waitrequest_out, // Wait request.
    input wire        selected_out,       // Selected flag.
    input wire        tag_first_en_out,   // Tag-first on.
    input wire        uplink_biphase_out, // Biphase coding.
    input wire [6:0]  uplink_bit_len_out, // Bit length.
    input wire [5:0]  tag_first_last_out, // Last page sent.
    input wire        pigeon_race_out     // Pigeon race on.
);
    // ====================================================
    // Marks the cycles after the first edge past reset release.
    reg run; // Config has been loaded.
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            run <= 1'b0;
        else
            run <= 1'b1;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // ====================================================
    // Handshake steps of one bus transfer.
    sequence s_start;
        $rose(av_read_in || av_write_in);
    endsequence
    sequence s_one_wait;
        av_waitrequest_out ##1 !av_waitrequest_out;
    endsequence
    property p_wait;
        s_start |-> s_one_wait;
    endproperty
    a_wait: assert property (p_wait) else $error("wait request not one cycle");
    property p_idle;
        !(av_read_in || av_write_in) |-> !av_waitrequest_out;
    endproperty
    a_idle: assert property (p_idle) else $error("wait request while idle");
    property p_rd_hold;
        !$stable(av_readdata_out) |-> $past(av_read_in);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_sel;
        $rose(selected_out) |-> $past(av_write_in);
    endproperty
    a_sel: assert property (p_sel) else $error("selected without a command");
    property p_cfg;
        run && $past(run) |-> $stable({tag_first_en_out, uplink_biphase_out, uplink_bit_len_out,
                                      tag_first_last_out, pigeon_race_out});
    endproperty
    a_cfg: assert property (p_cfg) else $error("config changed without reset");
    property p_len;
        uplink_bit_len_out inside {`TCA_BITLEN_2K, `TCA_BITLEN_4K, `TCA_BITLEN_8K};
    endproperty
    a_len: assert property (p_len) else $error("bad uplink bit length");
    property p_last;
        !tag_first_en_out |-> tag_first_last_out == 6'h04;
    endproperty
    a_last: assert property (p_last) else $error("bad last page when off");
    property p_pig;
        pigeon_race_out |-> uplink_bit_len_out == `TCA_BITLEN_2K;
    endproperty
    a_pig: assert property (p_pig) else $error("pigeon race not at 2 kbit");
endmodule
bind tca_top tca_chk u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .av_read_in(av_read_in),
    .av_write_in(av_write_in), .av_readdata_out(av_readdata_out), .av_waitrequest_out(av_waitrequest_out),
    .selected_out(selected_out), .tag_first_en_out(tag_first_en_out), .uplink_biphase_out(uplink_biphase_out),
    .uplink_bit_len_out(uplink_bit_len_out), .tag_first_last_out(tag_first_last_out),
    .pigeon_race_out(pigeon_race_out));

// >>> test/tca_rwd_model.sv
// Reader unit model that issues register transfers on the bus.
`timescale 1ns/1ps
module tca_reader_model
(
    input  wire        clk_in,    // Clock.
    input  wire        wait_in,   // Wait request.
    input  wire [31:0] rdata_in,  // Read data.
    output reg  [8:0]  addr_out,  // Address.
    output reg         rd_out,    // Read request.
    output reg         wr_out,    // Write request.
    output reg  [31:0] wdata_out, // Write data.
    output reg  [3:0]  be_out     // Byte enables.
);
    initial
    begin
        {addr_out, rd_out, wr_out, wdata_out, be_out} = '0;
    end
    // ====================================================
    // One transfer; held until wait is sampled low, then the bus shows junk.
    task xfer(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] b,
              output logic [31:0] q);
        begin
            @(posedge clk_in);
            addr_out  <= a;
            wdata_out <= d;
            be_out    <= b;
            rd_out    <= !w;
            wr_out    <= w;
            @(posedge clk_in);
            while (wait_in)
                @(posedge clk_in);
            q = rdata_in;
            rd_out    <= 1'b0;
            wr_out    <= 1'b0;
            addr_out  <= ~a;
            wdata_out <= ~d;
        end
    endtask
endmodule

// >>> test/test_transponder_config_access_control.sv
// Self-checking bench of the config page store and access checker.
`timescale 1ns/1ps
`include "tca_defs.vh"
module test_transponder_config_access_control;
    logic        clk_in = 0;      // Clock.
    logic        resetn_in = 0;   // Reset, low active.
    logic        nvm_init_in = 1; // Delivery image load.
    wire  [8:0]  adr;             // Bus address.
    wire         rd;              // Read request.
    wire         wr;              // Write request.
    wire  [31:0] wd;              // Write data.
    wire  [3:0]  be;              // Byte enables.
    wire  [31:0] rdat;            // Read data.
    wire         wt;              // Wait request.
    wire         sel;             // Selected.
    wire  [15:0] tf;              // Tag-first outputs packed.
    logic [31:0] q;               // Last read data.
    int          error_cnt = 0;   // Mismatches.
    int          checks = 0;      // Comparisons.
    always #25 clk_in = ~clk_in;
    tca_reader_model u_rdr (.clk_in(clk_in), .wait_in(wt), .rdata_in(rdat), .addr_out(adr), .rd_out(rd),
        .wr_out(wr), .wdata_out(wd), .be_out(be));
    tca_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .av_address_in(adr), .av_read_in(rd),
        .av_write_in(wr), .av_writedata_in(wd), .av_byteenable_in(be), .av_readdata_out(rdat),
        .av_waitrequest_out(wt), .nvm_init_in(nvm_init_in), .selected_out(sel), .tag_first_en_out(tf[1]),
        .uplink_biphase_out(tf[15]), .uplink_bit_len_out(tf[14:8]), .tag_first_last_out(tf[7:2]),
        .pigeon_race_out(tf[0]));
    // ====================================================
    // Shared helpers.
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr_t(input logic [8:0] a, input logic [31:0] d, input logic [3:0] b);
        u_rdr.xfer(1'b1, a, d, b, q);
    endtask
    task rd_t(input logic [8:0] a);
        u_rdr.xfer(1'b0, a, 32'h0, 4'h0, q);
    endtask
    function logic [8:0] pg(input int p);
        return 9'h100 + 9'(p * 4);
    endfunction
    task rst;
        resetn_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        // The config copy lands at the first edge; one more lets it settle before a look.
        repeat (2) @(posedge clk_in);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ====================================================
    // Scenarios.
    task t_delivery;
        rd_t(pg(1));
        chk("size", {30'h0, q[1:0]}, 32'h2);
        chk("page1", {8'h0, q[31:8]}, 32'h00AA_0000);
        chk("tf", {16'h0, tf}, {16'h0, 1'b0, `TCA_BITLEN_4K, 6'h04, 2'b00});
        wr_t(pg(1), 32'hFFFF_FFFF, 4'b0001);
        rd_t(`TCA_ACCESS_OFS);
        chk("refused", {31'h0, q[0]}, 32'h1);
        rd_t(pg(1));
        chk("memtype", {24'h0, q[7:0]}, {24'h0, 6'h00, `TCA_SIZE_CODE});
    endtask
    task t_tagfirst;
        logic [7:0]  c1v [4];
        logic [15:0] tfe [4];
        c1v = '{8'h04, 8'h58, 8'h2C, 8'h30};
        tfe = '{{1'b0, `TCA_BITLEN_4K, 6'h05, 2'b10}, {1'b1, `TCA_BITLEN_8K, 6'h07, 2'b10},
                {1'b0, `TCA_BITLEN_2K, 6'h04, 2'b10}, {1'b0, `TCA_BITLEN_2K, 6'h04, 2'b01}};
        for (int i = 0; i < 4; i++)
        begin
            wr_t(pg(1), {16'h0, c1v[i], 8'h0}, 4'b0010);
            rd_t(`TCA_STATUS_OFS);
            chk("inforce", {24'h0, q[15:8]}, {24'h0, i == 0 ? 8'h00 : c1v[(i + 3) % 4]});
            rst();
            chk("tf", {16'h0, tf}, {16'h0, tfe[i]});
        end
    endtask
    task t_plain_select;
        wr_t(`TCA_CTRL_OFS, 32'h1, 4'b0001);
        rd_t(`TCA_STATUS_OFS);
        chk("sel", {29'h0, q[2:0]}, 32'h1);
        chk("selpin", {31'h0, sel}, 32'h1);
        wr_t(`TCA_CTRL_OFS, 32'h4, 4'b0001);
        rd_t(`TCA_STATUS_OFS);
        chk("desel", {31'h0, q[0]}, 32'h0);
    endtask
    task t_locks;
        int lp [8];
        lp = '{5, 7, 11, 15, 23, 31, 47, 63};
        wr_t(pg(2), 32'h1122_3344, 4'hF);
        wr_t(pg(1), 32'h0055_0100, 4'b0110);
        rst();
        wr_t(pg(2), 32'hFFFF_FFFF, 4'hF);
        rd_t(pg(2));
        chk("pg2", q, 32'h1122_3344);
        rd_t(`TCA_ACCESS_OFS);
        chk("pg2rd", {31'h0, q[1]}, 32'h0);
        for (int g = 0; g < 8; g++)
        begin
            wr_t(pg(lp[g]), 32'hA5A5_A5A5, 4'hF);
            rd_t(pg(lp[g]));
            chk("grp", q, (8'h55 >> (7 - g)) & 8'h1 ? 32'h0 : 32'hA5A5_A5A5);
        end
    endtask
    task t_secure;
        wr_t(pg(1), 32'h0080_B300, 4'b0110);
        wr_t(pg(1), 32'h0000_B100, 4'b0010);
        rd_t(pg(1));
        chk("cfglockbit", {24'h0, q[15:8]}, 32'hB3);
        rst();
        wr_t(`TCA_CTRL_OFS, 32'h1, 4'b0001);
        rd_t(`TCA_STATUS_OFS);
        chk("authpend", {29'h0, q[2:0]}, 32'h4);
        wr_t(`TCA_CTRL_OFS, 32'h2, 4'b0001);
        rd_t(`TCA_STATUS_OFS);
        chk("authsel", {29'h0, q[2:0]}, 32'h1);
        rd_t(pg(2));
        rd_t(`TCA_ACCESS_OFS);
        chk("keyhid", {31'h0, q[1]}, 32'h1);
        wr_t(pg(5), 32'hFFFF_FFFF, 4'hF);
        rd_t(pg(5));
        chk("pigeon", q, 32'hFFFF_A5A5);
        wr_t(pg(1), 32'h0001_0000, 4'b0110);
        wr_t(pg(1), 32'h0000_0000, 4'b0100);
        rd_t(pg(1));
        chk("pwhi", {24'h0, q[31:24]}, 32'h0);
        chk("otp", {16'h0, q[23:8]}, 32'h81B3);
        rst();
        rd_t(`TCA_STATUS_OFS);
        chk("otpforce", {16'h0, q[23:8]}, 32'h81B3);
    endtask
    // ====================================================
    // Main sequence and watchdog.
    initial
    begin
        repeat (10) @(posedge clk_in);
        nvm_init_in <= 1'b0;
        resetn_in   <= 1'b1;
        @(posedge clk_in);
        t_delivery();
        t_tagfirst();
        t_plain_select();
        t_locks();
        t_secure();
        give_verdict();
    end
    initial
    begin
        #250000;
        error_cnt++;
        give_verdict();
    end
endmodule
